/* File: verification/hlsc_host_model.sv */
// Host computer model driving its ready line at the far side.
module hlsc_host_model (
	// Clock and bench command.
	input  wire logic aclk,
	input  wire logic want_ready,
	// Host ready line.
	output logic      host_ready_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// The host copies the bench command onto its line at each rising edge, through a nonblocking update.
	always @(posedge aclk) begin
		host_ready_in <= want_ready;
	end
	initial host_ready_in = 1'b0;
endmodule

/* File: verification/hlsc_top_asserts.sv */
// Concurrent checks on the host link status and control block ports.
module hlsc_chk (
	// Clock, reset and bus response.
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       s_axi_bvalid,
	// DMA events and levels.
	input wire logic [1:0] start_pls,
	input wire logic [1:0] restart_pls,
	input wire logic [1:0] eom_pls,
	input wire logic [1:0] bus_abort_pls,
	input wire logic [1:0] pi_req,
	input wire logic [1:0] err_line,
	// Host side.
	input wire logic       node_ready_relay,
	input wire logic       host_drv_en,
	input wire logic       loop_active
);
	timeunit 1ns;
	timeprecision 1ps;
	// One clock domain, so one default clocking and disable.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// A start makes the half busy, and busy drives its error line.
	a_start_err_tx: assert property (start_pls[0] |=> err_line[0])
		else $error("tx error line low after start");
	a_start_err_rx: assert property (start_pls[1] |=> err_line[1])
		else $error("rx error line low after start");
	// End of message always asks for a pseudo-interrupt.
	a_eom_pi: assert property (eom_pls[0] |=> pi_req[0])
		else $error("no interrupt after end of message");
	// An abort with no new cause drops the pending attempt; a low error line means the half is idle,
	// since an abort on a busy half is itself a fresh cause.
	a_abort_drop: assert property (pi_req[0] && bus_abort_pls[0] && !eom_pls[0] && !restart_pls[0]
		&& !start_pls[0] && !err_line[0] |=> !pi_req[0]) else $error("interrupt kept after abort");
	// An interrupt never appears without an event or a register write; a write acts in the same
	// edge that raises its response, so the response rises together with the interrupt.
	a_pi_cause: assert property ($rose(pi_req[0]) |->
		($past(eom_pls[0] || restart_pls[0] || bus_abort_pls[0]) || $rose(s_axi_bvalid)))
		else $error("interrupt without cause");
	// The relay stays open while the port is looped.
	a_relay_loop: assert property (loop_active [*2] |-> !node_ready_relay)
		else $error("relay closed while looped");
	// Looping sends data back inside, so host drivers are off.
	a_drv_loop: assert property (loop_active [*2] |-> !host_drv_en)
		else $error("drivers on while looped");
	// Loop state moves only by a register write, in the edge that raises the write response.
	a_loop_write: assert property ($changed(loop_active) |-> $rose(s_axi_bvalid))
		else $error("loop state moved without a write");

	// Main scenarios reached.
	cover property (eom_pls[0] ##1 pi_req[0]);
	cover property (bus_abort_pls[0] && pi_req[0]);
	cover property ($rose(loop_active));
	cover property ($fell(host_drv_en));
endmodule

bind hlsc_top hlsc_chk u_chk (.aclk, .aresetn, .s_axi_bvalid, .start_pls, .restart_pls, .eom_pls,
	.bus_abort_pls, .pi_req, .err_line, .node_ready_relay, .host_drv_en, .loop_active);

/* File: verification/hlsc_top_bench.sv */
// Self-checking bench for the host link status and control block.
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module hlsc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import hlsc_pkg::*;
	// Bench drives and design outputs.
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, want_ready = 1'b1, host_ready_in;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, rd_d;
	logic [1:0] start_pls = '0, restart_pls = '0, eom_pls = '0, bus_abort_pls = '0, pi_done_pls = '0, resp;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp, pi_req, err_line;
	wire logic [31:0] s_axi_rdata;
	wire logic node_ready_relay, host_drv_en, loop_active, pad_type;
	// Reference model state, plain integers.
	int bad_count = 0, checks = 0, seed = 32'h593323e8;
	int lp, nr, cr = 1, herr, ee, en, dof, bz[2], pi[2], re[2];

	// Timer shortened so expiry fits in a short run.
	hlsc_top #(.TIMEOUT_CYCLES(64)) u_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .start_pls, .restart_pls, .eom_pls,
		.bus_abort_pls, .pi_done_pls, .pi_req, .err_line, .host_ready_in, .node_ready_relay, .host_drv_en,
		.loop_active, .pad_type);
	hlsc_host_model u_host (.aclk, .want_ready, .host_ready_in);

	// Free-running 50 MHz clock.
	always #10 aclk = ~aclk;

	// Verdict and end of run.
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Model outputs.
	function automatic logic el(int h);
		return (bz[h] | re[h] | (h & herr)) != 0;
	endfunction
	function automatic logic hr();
		return lp ? 1'(nr) : (cr ? want_ready : 1'b1);
	endfunction
	function automatic logic [31:0] st(int h);
		return {22'h0, el(h), 1'b0, 1'(pi[h]), 1'(bz[h]), 1'(en), 1'(ee), 1'(herr), hr(), 1'(nr), 1'(lp)};
	endfunction
	// A reset form that hits a busy half interrupts it.
	function automatic void hrst(int h);
		if (bz[h]) begin
			pi[h] = 1;
			re[h] = 1;
		end
		bz[h] = 0;
	endfunction

	// Compare the design's levels with the model, away from the edge.
	task automatic cp();
		#1;
		`CHK(pi_req, {1'(pi[1]), 1'(pi[0])})
		`CHK(err_line, {el(1), el(0)})
		`CHK(node_ready_relay, 1'(nr && !lp && cr))
		`CHK(host_drv_en, 1'(!dof && !lp))
		`CHK(loop_active, 1'(lp))
	endtask

	// Bus write; bready held until the response edge.
	task automatic wr(logic [7:0] a, logic [31:0] d);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d | (32'($random(seed)) & 32'hfffff800);
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 40) begin
			bad_count++;
			finish_test();
		end
	endtask

	// Bus read; rready held until the data edge.
	task automatic rd(logic [7:0] a);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rd_d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n == 40) begin
			bad_count++;
			finish_test();
		end
	endtask

	// Status read compared with the model.
	task automatic rs(int h);
		rd(h ? RCV_STAT_OFS : XMT_STAT_OFS);
		`CHK(rd_d & 32'h3ff, st(h))
	endtask

	// Status write: loop, node ready and half reset.
	task automatic ws(int h, int d);
		wr(h ? RCV_STAT_OFS : XMT_STAT_OFS, 32'(d));
		if (nr && !d[1]) {herr, en} = {32'd1, 32'd1};
		if (d[1]) dof = 0;
		nr = d[1];
		if (lp != d[0]) for (int i = 0; i < 2; i++) hrst(i);
		if (d[8]) hrst(h);
		lp = d[0];
		repeat (2) @(posedge aclk);
		cp();
	endtask

	// Config write.
	task automatic wc(int d);
		wr(CFG_OFS, 32'(d));
		cr = d[0];
		repeat (2) @(posedge aclk);
		cp();
	endtask

	// Host line change; a fall while unlooped with ready on is an error.
	task automatic hs(logic v);
		if (!v && want_ready && !lp && cr) {herr, en} = {32'd1, 32'd1};
		want_ready <= v;
		repeat (4) @(posedge aclk);
		cp();
	endtask

	// One-cycle DMA event: 0 start, 1 restart, 2 end, 3 abort, 4 done.
	task automatic ev(int k, int h);
		logic [1:0] m;
		m = 2'(1 << h);
		@(posedge aclk);
		case (k)
			0: start_pls <= m;
			1: restart_pls <= m;
			2: eom_pls <= m;
			3: bus_abort_pls <= m;
			default: pi_done_pls <= m;
		endcase
		@(posedge aclk);
		{start_pls, restart_pls, eom_pls, bus_abort_pls, pi_done_pls} <= '0;
		@(posedge aclk);
		case (k)
			0: begin
				bz[h] = 1;
				re[h] = 0;
				if (h == 1) {herr, ee, en} = '0;
			end
			1: hrst(h);
			2: begin
				ee = ee | (h & herr);
				bz[h] = 0;
				pi[h] = 1;
			end
			3: pi[h] = bz[h];
			default: pi[h] = 0;
		endcase
		cp();
	endtask

	// Hang guard.
	initial begin
		repeat (100000) @(posedge aclk);
		bad_count++;
		finish_test();
	end

	// Main sequence.
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(CFG_OFS);
		`CHK(rd_d, 32'(CFG_RESET))
		wc(1);
		rs(0);
		ws(0, 2);
		rs(1);
		ev(0, 0);
		ev(2, 0);
		rs(0);
		ev(4, 0);
		ev(0, 1);
		ev(1, 1);
		rs(1);
		ev(4, 1);
		ev(0, 1);
		ev(2, 1);
		ev(4, 1);
		ev(2, 0);
		ev(3, 0);
		ev(0, 0);
		ev(3, 0);
		ev(1, 0);
		ev(4, 0);
		ev(0, 0);
		ws(0, 32'h102);
		ev(4, 0);
		ev(0, 0);
		ev(0, 1);
		ws(0, 3);
		rs(1);
		ev(4, 0);
		ev(4, 1);
		ws(1, 2);
		wc(4);
		`CHK(pad_type, 1'b1)
		hs(0);
		rs(0);
		hs(1);
		wc(1);
		hs(0);
		rs(1);
		hs(1);
		ev(2, 1);
		rs(1);
		ev(4, 1);
		ev(0, 1);
		rs(1);
		ev(2, 1);
		ev(4, 1);
		repeat (70) @(posedge aclk);
		{nr, herr, en, dof} = {32'd0, 32'd1, 32'd1, 32'd1};
		wc(3);
		rs(0);
		ws(0, 2);
		// Keep-alive writes well inside the shortened timeout.
		for (int i = 0; i < 4; i++) begin
			repeat (30 + ($random(seed) & 15)) @(posedge aclk);
			ws(1, 2);
		end
		repeat (80) @(posedge aclk);
		{nr, herr, en, dof} = {32'd0, 32'd1, 32'd1, 32'd1};
		cp();
		ws(0, 2);
		ws(0, 0);
		rs(1);
		ws(0, 3);
		// Master reset in mid-run; three edges so the checks stay disabled while the loop drops.
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		{lp, nr, herr, ee, en, dof} = '0;
		cr = 1;
		bz = '{0, 0};
		pi = '{0, 0};
		re = '{0, 0};
		rs(0);
		cp();
		rd(8'h0c);
		`CHK({resp, rd_d}, {RESP_SLVERR, 32'h0})
		wr(8'h0c, 32'h3);
		`CHK(resp, RESP_SLVERR)
		finish_test();
	end
endmodule

/* File: verilog/hlsc_pkg.sv */
// Package of constants shared by the host link status and control block.
package hlsc_pkg;

	// Clock and driver timeout timing.
	localparam int unsigned CLK_HZ          = 50_000_000;
	localparam int unsigned TIMEOUT_MS      = 1000;
	localparam int unsigned TIMEOUT_CYCLES  = (CLK_HZ / 1000) * TIMEOUT_MS;

	// Bus geometry and timer width.
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;
	localparam int          TMR_W           = 32;

	// Register byte offsets.
	localparam logic [7:0]  XMT_STAT_OFS    = 8'h00;
	localparam logic [7:0]  RCV_STAT_OFS    = 8'h04;
	localparam logic [7:0]  CFG_OFS         = 8'h08;

	// Status word fields, written; loop and node ready read back, half reset reads as zero.
	localparam int          LOOP_BIT        = 0;
	localparam int          NODE_RDY_BIT    = 1;
	localparam int          HALF_RST_BIT    = 8;
	// Status word fields, read only.
	localparam int          HOST_RDY_BIT    = 2;
	localparam int          HOST_ERR_BIT    = 3;
	localparam int          ERR_EOM_BIT     = 4;
	localparam int          ERR_NOEOM_BIT   = 5;
	localparam int          BUSY_BIT        = 6;
	localparam int          PI_PEND_BIT     = 7;
	localparam int          ERR_LINE_BIT    = 9;
	localparam int          DRV_OFF_BIT     = 10;

	// Configuration fields and reset value.
	localparam int          CFG_RDY_EN_BIT  = 0;
	localparam int          CFG_TMR_EN_BIT  = 1;
	localparam int          CFG_PAD_BIT     = 2;
	localparam logic [2:0]  CFG_RESET       = 3'h3;

	// Half indices.
	localparam int          XMT             = 0;
	localparam int          RCV             = 1;

	// Bus responses.
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage

/* File: verilog/hlsc_top.sv */
// Host link status and control logic with its register slave.
// Contract
// - Each half interrupts on five event kinds
// - Bus abort abandons a pending interrupt attempt
// - Loop change resets both halves together
// - Loop change interrupts each busy half
// - Loop readback true; unloop by reset, write
// - Start pulse sets the half busy
// - Busy cleared by reset, restart, end
// - Node ready needs set and no timeout
// - Relay closed when enabled, unlooped, ready
// - Node ready cleared by write, reset, timeout
// - Looped host ready equals node ready
// - Unlooped host ready follows option or line
// - Host error on host or node fall
// - Receive start clears host error
// - Receive error line shows host error
// - Separate error bits with, without end
// - Error line: busy or reset interrupt
// - Software loop sends data back internally
// - Timeout keeps one card driving link
// - Options: ready ignore, timer, padding
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
module hlsc_top #(
	parameter int unsigned TIMEOUT_CYCLES = hlsc_pkg::TIMEOUT_CYCLES
) (
	// Clock and reset.
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// Write address channel.
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [hlsc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]                  s_axi_awprot,
	// Write data channel.
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	input  wire logic [hlsc_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	// Write response channel.
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	output logic [1:0]                       s_axi_bresp,
	// Read address channel.
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	input  wire logic [hlsc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                  s_axi_arprot,
	// Read data channel.
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	output logic [hlsc_pkg::DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	// DMA unit events, index 0 transmit and 1 receive, one-cycle pulses.
	input  wire logic [1:0]                  start_pls,
	input  wire logic [1:0]                  restart_pls,
	input  wire logic [1:0]                  eom_pls,
	input  wire logic [1:0]                  bus_abort_pls,
	input  wire logic [1:0]                  pi_done_pls,
	// DMA unit levels.
	output logic [1:0]                       pi_req,
	output logic [1:0]                       err_line,
	// Host side.
	input  wire logic                        host_ready_in,
	output logic                             node_ready_relay,
	output logic                             host_drv_en,
	output logic                             loop_active,
	output logic                             pad_type
);
	import hlsc_pkg::*;

	typedef struct packed {
		logic                awready;
		logic                wready;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [1:0]          rresp;
		logic [DATA_W-1:0]   rdata;
		logic                aw_have;
		logic                w_have;
		logic [ADDR_W-1:0]   aw_addr;
		logic [DATA_W-1:0]   w_data;
		logic [3:0]          w_strb;
		logic                loop;
		logic                node_rdy;
		logic                drv_off;
		logic [2:0]          cfg;
		logic [TMR_W-1:0]    tmr;
		logic [1:0]          busy;
		logic [1:0]          pi;
		logic [1:0]          rst_err;
		logic [1:0]          err_out;
		logic                host_rdy;
		logic                host_err;
		logic                err_eom;
		logic                err_noeom;
		logic                relay;
		logic                drv_en;
	} hlsc_state_t;

	localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(TIMEOUT_CYCLES - 1);

	hlsc_state_t state_reg;
	hlsc_state_t state_next;

	// Builds one half's status word from the present state.
	function automatic logic [DATA_W-1:0] stat_word(input hlsc_state_t s, input int h);
		logic [DATA_W-1:0] v;
		v                = '0;
		v[LOOP_BIT]      = s.loop;
		v[NODE_RDY_BIT]  = s.node_rdy;
		v[HOST_RDY_BIT]  = s.host_rdy;
		v[HOST_ERR_BIT]  = s.host_err;
		v[ERR_EOM_BIT]   = s.err_eom;
		v[ERR_NOEOM_BIT] = s.err_noeom;
		v[BUSY_BIT]      = s.busy[h];
		v[PI_PEND_BIT]   = s.pi[h];
		v[ERR_LINE_BIT]  = s.err_out[h];
		v[DRV_OFF_BIT]   = s.drv_off;
		return v;
	endfunction

	// True when an address names one of the two status words.
	function automatic logic is_stat(input logic [ADDR_W-1:0] a);
		return (a == XMT_STAT_OFS) || (a == RCV_STAT_OFS);
	endfunction

	// Next-state logic for the bus slave and all link control state.
	always_comb begin
		logic       wr_go;
		logic       kick;
		logic       loop_wr;
		logic       loop_chg;
		logic       nr_wr;
		logic [1:0] hrst;
		logic [1:0] rst_any;
		logic       expire;
		logic       herr_evt;
		int         wh;
		wr_go      = 1'b0;
		kick       = 1'b0;
		loop_wr    = 1'b0;
		loop_chg   = 1'b0;
		nr_wr      = 1'b0;
		hrst       = 2'h0;
		rst_any    = 2'h0;
		expire     = 1'b0;
		herr_evt   = 1'b0;
		wh         = XMT;
		state_next = state_reg;

		// Address and data are taken in either order; the write acts once both are held.
		if (s_axi_awvalid && state_reg.awready) begin
			state_next.aw_have = 1'b1;
			state_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && state_reg.wready) begin
			state_next.w_have = 1'b1;
			state_next.w_data = s_axi_wdata;
			state_next.w_strb = s_axi_wstrb;
		end
		if (state_reg.bvalid && s_axi_bready) begin
			state_next.bvalid = 1'b0;
		end
		if (state_reg.aw_have && state_reg.w_have && !state_reg.bvalid) begin
			wr_go              = 1'b1;
			state_next.aw_have = 1'b0;
			state_next.w_have  = 1'b0;
			state_next.bvalid  = 1'b1;
			state_next.bresp   = RESP_OKAY;
			if (!is_stat(state_reg.aw_addr) && state_reg.aw_addr != CFG_OFS) begin
				state_next.bresp = RESP_SLVERR;
			end
		end
		// Only one write is in flight, so both channels close until the response is taken.
		state_next.awready = !state_next.aw_have && !state_next.bvalid;
		state_next.wready  = !state_next.w_have && !state_next.bvalid;

		// Register write effects.
		if (wr_go && is_stat(state_reg.aw_addr)) begin
			wh      = (state_reg.aw_addr == RCV_STAT_OFS) ? RCV : XMT;
			kick    = 1'b1;
			loop_wr = state_reg.w_strb[0];
			nr_wr   = state_reg.w_strb[0];
			hrst[wh] = state_reg.w_strb[1] && state_reg.w_data[HALF_RST_BIT];
		end
		if (wr_go && state_reg.aw_addr == CFG_OFS && state_reg.w_strb[0]) begin
			state_next.cfg = state_reg.w_data[2:0];
		end

		// Reads answer from the present state; unmapped addresses read zero with an error.
		if (s_axi_arvalid && state_reg.arready) begin
			state_next.arready = 1'b0;
			state_next.rvalid  = 1'b1;
			state_next.rresp   = RESP_OKAY;
			state_next.rdata   = '0;
			if (s_axi_araddr == XMT_STAT_OFS) begin
				state_next.rdata = stat_word(state_reg, XMT);
			end else if (s_axi_araddr == RCV_STAT_OFS) begin
				state_next.rdata = stat_word(state_reg, RCV);
			end else if (s_axi_araddr == CFG_OFS) begin
				state_next.rdata[2:0] = state_reg.cfg;
			end else begin
				state_next.rresp = RESP_SLVERR;
			end
		end else if (state_reg.rvalid && s_axi_rready) begin
			state_next.rvalid  = 1'b0;
			state_next.arready = 1'b1;
		end

		// Loop state follows the written bit; any change resets both halves at once.
		if (loop_wr) begin
			state_next.loop = state_reg.w_data[LOOP_BIT];
		end
		loop_chg = loop_wr && (state_reg.w_data[LOOP_BIT] != state_reg.loop);

		// Per-half busy, pseudo-interrupt and reset-error tracking.
		for (int h = 0; h < 2; h++) begin
			rst_any[h] = hrst[h] || restart_pls[h] || loop_chg;
			// Start wins over a coincident clear so a fresh transfer is never lost.
			state_next.busy[h] = start_pls[h] ||
				(state_reg.busy[h] && !rst_any[h] && !eom_pls[h]);
			// An abort drops a waiting attempt; a new cause in the same cycle still sets it.
			state_next.pi[h] = eom_pls[h] ||
				(state_reg.busy[h] && (rst_any[h] || bus_abort_pls[h])) ||
				(state_reg.pi[h] && !pi_done_pls[h] && !bus_abort_pls[h]);
			state_next.rst_err[h] = (state_reg.busy[h] && rst_any[h]) ||
				(state_reg.rst_err[h] && !start_pls[h]);
		end

		// Driver timeout; each status write restarts it, and it saturates once expired.
		if (kick) begin
			state_next.tmr = '0;
		end else if (state_reg.tmr != TMR_LAST) begin
			state_next.tmr = state_reg.tmr + 1'b1;
		end
		expire = state_reg.cfg[CFG_TMR_EN_BIT] && !kick && state_reg.tmr == TMR_LAST;
		if (expire) begin
			state_next.node_rdy = 1'b0;
			state_next.drv_off  = 1'b1;
		end
		if (nr_wr) begin
			state_next.node_rdy = state_reg.w_data[NODE_RDY_BIT];
			if (state_reg.w_data[NODE_RDY_BIT]) begin
				state_next.drv_off = 1'b0;
			end
		end

		// Host ready view; the host line is ignored when the ready option is off.
		if (state_next.loop) begin
			state_next.host_rdy = state_next.node_rdy;
		end else begin
			state_next.host_rdy = !state_reg.cfg[CFG_RDY_EN_BIT] || host_ready_in;
		end

		// A falling host ready only counts while the port stays unlooped across the edge.
		herr_evt = (state_reg.host_rdy && !state_next.host_rdy && !state_reg.loop && !state_next.loop) ||
			(state_reg.node_rdy && !state_next.node_rdy);
		state_next.host_err = herr_evt || (state_reg.host_err && !start_pls[RCV]);
		state_next.err_eom = ((herr_evt || state_reg.host_err) && eom_pls[RCV]) ||
			(state_reg.err_eom && !start_pls[RCV]);
		state_next.err_noeom = (herr_evt && !eom_pls[RCV]) ||
			(state_reg.err_noeom && !start_pls[RCV]);

		// Error lines to the DMA unit.
		state_next.err_out[XMT] = state_next.busy[XMT] || state_next.rst_err[XMT];
		state_next.err_out[RCV] = state_next.busy[RCV] || state_next.rst_err[RCV] ||
			state_next.host_err;

		// Relay and drivers; looping keeps this card off the shared host cable.
		state_next.relay  = state_next.cfg[CFG_RDY_EN_BIT] && !state_next.loop &&
			state_next.node_rdy;
		state_next.drv_en = !state_next.loop && !state_next.drv_off;
	end

	// State register; synchronous reset acts as the master reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg          <= '0;
			state_reg.awready  <= 1'b1;
			state_reg.wready   <= 1'b1;
			state_reg.arready  <= 1'b1;
			state_reg.cfg      <= CFG_RESET;
			state_reg.host_rdy <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// Every output comes straight from the state register.
	assign s_axi_awready    = state_reg.awready;
	assign s_axi_wready     = state_reg.wready;
	assign s_axi_bvalid     = state_reg.bvalid;
	assign s_axi_bresp      = state_reg.bresp;
	assign s_axi_arready    = state_reg.arready;
	assign s_axi_rvalid     = state_reg.rvalid;
	assign s_axi_rdata      = state_reg.rdata;
	assign s_axi_rresp      = state_reg.rresp;
	assign pi_req           = state_reg.pi;
	assign err_line         = state_reg.err_out;
	assign node_ready_relay = state_reg.relay;
	assign host_drv_en      = state_reg.drv_en;
	assign loop_active      = state_reg.loop;
	assign pad_type         = state_reg.cfg[CFG_PAD_BIT];

endmodule
